// File: ckg_ctrl.sv
// What this block does
// [R1] resets into self-clocked mode, about 8 MHz
// [R2] scheme 11 selects loop with external reference
// [R3] filter readable; writable only in self-clocked mode
// [R4] self-clocked upper write loads full 12-bit filter
// [R5] upper write ignored while latch still pending
// [R6] trim binary weighted; larger value, longer period
// [R7] gain bit clear selects low-power oscillator
// [R8] range bit set: high range, prescale one
// [R9] stop-keep clear stops oscillator in stop
// [R10] control bit 0 always reads zero
// [R11] crystal pins take port G bits 2, 1
// [R12] bus clock is generator output halved
`timescale 1ns/1ps
module ckg_ctrl #(
   parameter int LATCH_CYCLES = ckg_pkg::LATCH_CYC
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic [31:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [31:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   input wire logic stop_mode,
   input wire logic [11:0] loop_filter_in,
   output logic generator_output_clock,
   output logic bus_clk,
   output logic osc_enable,
   output logic osc_low_power,
   output logic osc_range_high,
   output logic ref_prescale_one,
   output logic loop_engaged_external,
   output logic loss_detect_on,
   output logic [1:0] active_scheme,
   output logic [7:0] port_g_claim
);
   // the latch counter is eight bits wide and must start above zero
   if (LATCH_CYCLES < 1 || LATCH_CYCLES > 255) begin : g_bad_latch
      $error("LATCH_CYCLES must lie in 1..255");
   end

   typedef struct packed {
      logic [7:0] ctrl_one;
      logic [7:0] trim;
      logic [11:0] filter;
      logic [7:0] lower_pend;
      logic [11:0] latch_val;
      logic [7:0] latch_cnt;
      logic busy;
      logic [11:0] loop_s1;
      logic [11:0] loop_s2;
      logic [11:0] loop_s3;
      logic osc_en;
      logic low_pwr;
      logic range_hi;
      logic lee;
      logic loss_on;
      logic [1:0] scheme;
      logic [7:0] pg_claim;
   } ckg_ctrl_t;

   ckg_ctrl_t st_r;
   ckg_ctrl_t st_nxt;
   logic [1:0] rst_sync_r;
   logic rst_n;
   logic [1:0] scheme_sel;
   logic self_mode;
   logic uses_int_ref;
   logic gen_out_w;
   logic bus_clk_w;
   logic gen_out_r;
   logic bus_clk_r;

   ckg_regbus_if rb ();

   // reset released through two flops, asserted at once
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   ckg_axil_slave u_bus (
      .clk(core_clk),
      .rst_n(rst_n),
      .s_awaddr(s_awaddr),
      .s_awvalid(s_awvalid),
      .s_awready(s_awready),
      .s_wdata(s_wdata),
      .s_wstrb(s_wstrb),
      .s_wvalid(s_wvalid),
      .s_wready(s_wready),
      .s_bresp(s_bresp),
      .s_bvalid(s_bvalid),
      .s_bready(s_bready),
      .s_araddr(s_araddr),
      .s_arvalid(s_arvalid),
      .s_arready(s_arready),
      .s_rdata(s_rdata),
      .s_rresp(s_rresp),
      .s_rvalid(s_rvalid),
      .s_rready(s_rready),
      .rb(rb.bus)
   );

   assign scheme_sel = st_r.ctrl_one[ckg_pkg::SCHEME_HI:ckg_pkg::SCHEME_LO];
   assign self_mode = (scheme_sel == ckg_pkg::SCHEME_SELF);
   assign uses_int_ref = (scheme_sel == ckg_pkg::SCHEME_SELF)
      || (scheme_sel == ckg_pkg::SCHEME_LOOP_INT);

   // filter steps the generator; trim only touches the internal reference
   ckg_clk_gen u_gen (
      .clk(core_clk),
      .rst_n(rst_n),
      .step(st_r.filter),
      .trim(st_r.trim), // R6
      .use_trim(uses_int_ref),
      .gen_out(gen_out_w),
      .bus_clk(bus_clk_w) // R12
   );

   // address decode for reads
   always_comb begin
      rb.rd_ok = 1'b1;
      rb.rd_data = 8'h00;
      if (rb.rd_addr == ckg_pkg::OFS_CTRL_ONE) begin
         rb.rd_data = {st_r.ctrl_one[7:1], 1'b0}; // R10
      end else if (rb.rd_addr == ckg_pkg::OFS_FILT_UPPER) begin
         rb.rd_data = {4'h0, st_r.filter[11:8]}; // R3
      end else if (rb.rd_addr == ckg_pkg::OFS_FILT_LOWER) begin
         rb.rd_data = st_r.filter[7:0]; // R3
      end else if (rb.rd_addr == ckg_pkg::OFS_TRIM) begin
         rb.rd_data = st_r.trim;
      end else if (rb.rd_addr == ckg_pkg::OFS_STATUS) begin
         rb.rd_data = {5'h00, st_r.busy, scheme_sel};
      end else begin
         rb.rd_ok = 1'b0;
      end
   end

   // address decode for writes
   always_comb begin
      rb.wr_ok = (rb.wr_addr == ckg_pkg::OFS_CTRL_ONE)
         || (rb.wr_addr == ckg_pkg::OFS_FILT_UPPER)
         || (rb.wr_addr == ckg_pkg::OFS_FILT_LOWER)
         || (rb.wr_addr == ckg_pkg::OFS_TRIM)
         || (rb.wr_addr == ckg_pkg::OFS_STATUS);
   end

   always_comb begin
      st_nxt = st_r;
      // loop filter arrives from the analog loop, not this clock
      st_nxt.loop_s1 = loop_filter_in;
      st_nxt.loop_s2 = st_r.loop_s1;
      st_nxt.loop_s3 = st_r.loop_s2;
      if (rb.wr_en) begin
         if (rb.wr_addr == ckg_pkg::OFS_CTRL_ONE) begin
            st_nxt.ctrl_one = {rb.wr_data[7:1], 1'b0}; // R10
         end else if (rb.wr_addr == ckg_pkg::OFS_TRIM) begin
            st_nxt.trim = rb.wr_data; // R6
         end else if (rb.wr_addr == ckg_pkg::OFS_FILT_LOWER && self_mode) begin
            st_nxt.lower_pend = rb.wr_data; // R3
         end else if (rb.wr_addr == ckg_pkg::OFS_FILT_UPPER && self_mode && !st_r.busy) begin
            // upper write commits upper nibble with the held lower byte
            st_nxt.latch_val = {rb.wr_data[3:0], st_r.lower_pend}; // R4
            st_nxt.latch_cnt = 8'(LATCH_CYCLES);
            st_nxt.busy = 1'b1;
         end
      end
      // latch sequence: writes to upper while busy fall through above
      if (st_r.busy) begin // R5
         if (st_r.latch_cnt == 8'h01) begin
            st_nxt.busy = 1'b0;
            st_nxt.latch_cnt = 8'h00;
            st_nxt.filter = st_r.latch_val; // R4
         end else begin
            st_nxt.latch_cnt = st_r.latch_cnt - 8'h01;
         end
      end
      // a pending latch is abandoned if the loop takes over
      if (!self_mode) begin
         st_nxt.busy = 1'b0;
         st_nxt.latch_cnt = 8'h00;
         // loop modes own the filter; software only reads it
         // a word caught mid-change differs between stages, so wait for two equal samples
         if (st_r.loop_s2 == st_r.loop_s3) begin
            st_nxt.filter = st_r.loop_s2; // R3
         end
      end
      st_nxt.osc_en = st_r.ctrl_one[ckg_pkg::REF_SEL_BIT]
         && !(stop_mode && !st_r.ctrl_one[ckg_pkg::STOP_KEEP_BIT]); // R9
      st_nxt.low_pwr = !st_r.ctrl_one[ckg_pkg::HIGH_GAIN_BIT]; // R7
      st_nxt.range_hi = st_r.ctrl_one[ckg_pkg::RANGE_BIT]; // R8
      st_nxt.lee = (scheme_sel == ckg_pkg::SCHEME_LOOP_EXT); // R2
      st_nxt.loss_on = !st_r.ctrl_one[ckg_pkg::LOSS_DIS_BIT];
      st_nxt.scheme = scheme_sel;
      st_nxt.pg_claim = 8'h00;
      st_nxt.pg_claim[2] = st_r.ctrl_one[ckg_pkg::REF_SEL_BIT]; // R11
      st_nxt.pg_claim[1] = st_r.ctrl_one[ckg_pkg::REF_SEL_BIT]; // R11
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
         st_r.ctrl_one <= ckg_pkg::CTRL_ONE_RST; // R1
         st_r.trim <= ckg_pkg::TRIM_RST;
         st_r.filter <= ckg_pkg::FILT_RST; // R1
         st_r.low_pwr <= 1'b1;
         st_r.range_hi <= 1'b1;
         st_r.loss_on <= 1'b1;
         gen_out_r <= 1'b0;
         bus_clk_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         gen_out_r <= gen_out_w;
         bus_clk_r <= bus_clk_w; // R12
      end
   end

   assign generator_output_clock = gen_out_r;
   assign bus_clk = bus_clk_r;
   assign osc_enable = st_r.osc_en;
   assign osc_low_power = st_r.low_pwr;
   assign osc_range_high = st_r.range_hi;
   assign ref_prescale_one = st_r.range_hi; // R8
   assign loop_engaged_external = st_r.lee;
   assign loss_detect_on = st_r.loss_on;
   assign active_scheme = st_r.scheme;
   assign port_g_claim = st_r.pg_claim;
endmodule : ckg_ctrl

// File: ckg_pkg.sv
package ckg_pkg;
   // register byte offsets on the AXI4-Lite bus
   localparam logic [7:0] OFS_CTRL_ONE = 8'h00;
   localparam logic [7:0] OFS_FILT_UPPER = 8'h04;
   localparam logic [7:0] OFS_FILT_LOWER = 8'h08;
   localparam logic [7:0] OFS_TRIM = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   // clock_gen_control_one field positions
   localparam int HIGH_GAIN_BIT = 7;
   localparam int RANGE_BIT = 6;
   localparam int REF_SEL_BIT = 5;
   localparam int SCHEME_HI = 4;
   localparam int SCHEME_LO = 3;
   localparam int STOP_KEEP_BIT = 2;
   localparam int LOSS_DIS_BIT = 1;
   // status register field positions
   localparam int STAT_BUSY_BIT = 2;
   // clock_scheme_select encodings
   localparam logic [1:0] SCHEME_SELF = 2'h0;
   localparam logic [1:0] SCHEME_LOOP_INT = 2'h1;
   localparam logic [1:0] SCHEME_BYPASS_EXT = 2'h2;
   localparam logic [1:0] SCHEME_LOOP_EXT = 2'h3;
   // reset values
   localparam logic [7:0] CTRL_ONE_RST = 8'h40;
   localparam logic [7:0] TRIM_RST = 8'h80;
   localparam int FILT_W = 12;
   // step of 0x333 on a 12-bit phase accumulator at 40 MHz gives about 8 MHz
   localparam logic [11:0] FILT_RST = 12'h333;
   localparam logic [11:0] NCO_STEP_MAX = 12'h7FF;
   // trim scale: step factor (0x280 - trim) / 0x200, so 0x80 is nominal, +-25 %
   localparam logic [9:0] TRIM_BASE = 10'h280;
   localparam int TRIM_SHIFT = 9;
   // timing
   localparam int CORE_CLK_HZ = 40_000_000;
   localparam int LATCH_NS = 200;
   localparam int LATCH_CYC = (LATCH_NS * (CORE_CLK_HZ / 1_000_000) + 999) / 1000;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ckg_pkg

// File: ckg_regbus_if.sv
`timescale 1ns/1ps
interface ckg_regbus_if;
   logic wr_en;
   logic [ckg_pkg::ADDR_W-1:0] wr_addr;
   logic [7:0] wr_data;
   logic wr_ok;
   logic [ckg_pkg::ADDR_W-1:0] rd_addr;
   logic [7:0] rd_data;
   logic rd_ok;
   modport bus (output wr_en, output wr_addr, output wr_data, input wr_ok,
      output rd_addr, input rd_data, input rd_ok);
   modport regs (input wr_en, input wr_addr, input wr_data, output wr_ok,
      input rd_addr, output rd_data, output rd_ok);
endinterface : ckg_regbus_if

// File: ckg_axil_slave.sv
`timescale 1ns/1ps
module ckg_axil_slave (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [31:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [31:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   ckg_regbus_if.bus rb
);
   typedef struct packed {
      logic aw_held;
      logic [7:0] aw_addr;
      logic w_held;
      logic [7:0] w_data;
      logic w_lane0;
      logic bvalid;
      logic [1:0] bresp;
      logic ar_held;
      logic [7:0] ar_addr;
      logic rvalid;
      logic [1:0] rresp;
      logic [7:0] rdata;
   } ckg_axs_t;

   ckg_axs_t st_r;
   ckg_axs_t st_nxt;
   logic do_write;

   always_comb begin
      st_nxt = st_r;
      do_write = st_r.aw_held && st_r.w_held && !st_r.bvalid;
      if (s_awvalid && s_awready) begin
         st_nxt.aw_held = 1'b1;
         st_nxt.aw_addr = s_awaddr[7:0];
      end
      if (s_wvalid && s_wready) begin
         st_nxt.w_held = 1'b1;
         st_nxt.w_data = s_wdata[7:0];
         st_nxt.w_lane0 = s_wstrb[0];
      end
      if (do_write) begin
         st_nxt.aw_held = 1'b0;
         st_nxt.w_held = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = rb.wr_ok ? ckg_pkg::RESP_OKAY : ckg_pkg::RESP_SLVERR;
      end else if (st_r.bvalid && s_bready) begin
         st_nxt.bvalid = 1'b0;
      end
      if (s_arvalid && s_arready) begin
         st_nxt.ar_held = 1'b1;
         st_nxt.ar_addr = s_araddr[7:0];
      end
      // one cycle to look up the addressed register, then rvalid
      if (st_r.ar_held) begin
         st_nxt.ar_held = 1'b0;
         st_nxt.rvalid = 1'b1;
         st_nxt.rdata = rb.rd_ok ? rb.rd_data : 8'h00;
         st_nxt.rresp = rb.rd_ok ? ckg_pkg::RESP_OKAY : ckg_pkg::RESP_SLVERR;
      end else if (st_r.rvalid && s_rready) begin
         st_nxt.rvalid = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // only byte lane 0 carries register bits; a write without it still answers
   assign rb.wr_en = do_write && st_r.w_lane0;
   assign rb.wr_addr = st_r.aw_addr;
   assign rb.wr_data = st_r.w_data;
   assign rb.rd_addr = st_r.ar_addr;
   assign s_awready = !st_r.aw_held && !st_r.bvalid;
   assign s_wready = !st_r.w_held && !st_r.bvalid;
   assign s_bvalid = st_r.bvalid;
   assign s_bresp = st_r.bresp;
   assign s_arready = !st_r.ar_held && !st_r.rvalid;
   assign s_rvalid = st_r.rvalid;
   assign s_rresp = st_r.rresp;
   assign s_rdata = {24'h000000, st_r.rdata};
endmodule : ckg_axil_slave

// File: ckg_clk_gen.sv
`timescale 1ns/1ps
module ckg_clk_gen (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [11:0] step,
   input wire logic [7:0] trim,
   input wire logic use_trim,
   output logic gen_out,
   output logic bus_clk
);
   typedef struct packed {
      logic [11:0] acc;
      logic gen;
      logic bus;
   } ckg_gen_t;

   ckg_gen_t st_r;
   ckg_gen_t st_nxt;
   logic [21:0] scaled;
   logic [12:0] eff;
   logic [11:0] eff_step;

   always_comb begin
      st_nxt = st_r;
      // larger trim lowers the step, which lengthens the period
      scaled = {10'h000, step} * {12'h000, (ckg_pkg::TRIM_BASE - {2'h0, trim})};
      eff = use_trim ? scaled[ckg_pkg::TRIM_SHIFT +: 13] : {1'b0, step};
      // above half the accumulator the output would alias, so clamp
      eff_step = (eff > {1'b0, ckg_pkg::NCO_STEP_MAX}) ? ckg_pkg::NCO_STEP_MAX : eff[11:0];
      st_nxt.acc = st_r.acc + eff_step;
      st_nxt.gen = st_nxt.acc[11];
      if (st_nxt.gen && !st_r.gen) begin
         st_nxt.bus = !st_r.bus;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign gen_out = st_r.gen;
   assign bus_clk = st_r.bus;
endmodule : ckg_clk_gen

// File: ckg_ctrl_asserts.sv
`timescale 1ns/1ps
module ckg_ctrl_chk #(
   parameter int LATCH_CYCLES = 8
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic s_awvalid,
   input wire logic s_awready,
   input wire logic s_wvalid,
   input wire logic s_wready,
   input wire logic s_bvalid,
   input wire logic s_arvalid,
   input wire logic s_arready,
   input wire logic s_rvalid,
   input wire logic generator_output_clock,
   input wire logic bus_clk,
   input wire logic osc_enable,
   input wire logic osc_range_high,
   input wire logic ref_prescale_one,
   input wire logic loop_engaged_external,
   input wire logic [1:0] active_scheme,
   input wire logic [7:0] port_g_claim
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!arst_n);
   sequence s_ar_taken;
      s_arvalid && s_arready;
   endsequence
   sequence s_wr_taken;
      s_awvalid && s_awready && s_wvalid && s_wready;
   endsequence
   sequence s_no_claim;
      !port_g_claim[2] ##1 !port_g_claim[2];
   endsequence
   a_read_latency: assert property (s_ar_taken |-> ##2 s_rvalid)
      else $error("read answer not two cycles after address");
   a_write_resp: assert property (s_wr_taken |-> ##2 s_bvalid)
      else $error("write answer not two cycles after handshake");
   a_write_block: assert property (s_bvalid |-> !s_awready && !s_wready)
      else $error("write taken while response pending");
   a_read_block: assert property (s_rvalid |-> !s_arready)
      else $error("read taken while data pending");
   a_bus_halved: assert property (
      $rose(generator_output_clock) |-> ##[0:2] $changed(bus_clk))
      else $error("bus clock missed a generator edge");
   a_scheme_ext: assert property (
      loop_engaged_external == (active_scheme == 2'h3))
      else $error("external loop flag disagrees with scheme");
   a_prescale_range: assert property (ref_prescale_one == osc_range_high)
      else $error("prescale one disagrees with range");
   a_claim_bits: assert property (
      port_g_claim[7:3] == 5'h0 && !port_g_claim[0] && port_g_claim[2] == port_g_claim[1])
      else $error("wrong port pins claimed");
   a_osc_needs_ref: assert property (s_no_claim |-> !osc_enable)
      else $error("oscillator on without reference request");
   a_reset_mode: assert property (
      $rose(arst_n) |-> active_scheme == 2'h0 && osc_range_high)
      else $error("not self-clocked after reset");
endmodule : ckg_ctrl_chk

bind ckg_ctrl ckg_ctrl_chk #(.LATCH_CYCLES(LATCH_CYCLES)) chk_u (.core_clk, .arst_n,
   .s_awvalid, .s_awready, .s_wvalid, .s_wready, .s_bvalid, .s_arvalid, .s_arready,
   .s_rvalid, .generator_output_clock, .bus_clk, .osc_enable, .osc_range_high,
   .ref_prescale_one, .loop_engaged_external, .active_scheme, .port_g_claim);

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
   localparam logic [7:0] A_CTL = ckg_pkg::OFS_CTRL_ONE;
   localparam logic [7:0] A_UP = ckg_pkg::OFS_FILT_UPPER;
   localparam logic [7:0] A_LO = ckg_pkg::OFS_FILT_LOWER;
   localparam logic [7:0] A_TRM = ckg_pkg::OFS_TRIM;
   logic core_clk, arst_n, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, stop_mode;
   logic [31:0] s_awaddr, s_wdata, s_araddr, s_rdata;
   logic [3:0] s_wstrb;
   logic [11:0] loop_filter_in;
   logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, generator_output_clock;
   logic bus_clk, osc_enable, osc_low_power, osc_range_high, ref_prescale_one;
   logic loop_engaged_external, loss_detect_on;
   logic [1:0] s_bresp, s_rresp, active_scheme;
   logic [7:0] port_g_claim;
   int fails, cmp_count;
   // long latch so a second upper write lands inside it
   ckg_ctrl #(.LATCH_CYCLES(20)) dut_u (.core_clk, .arst_n, .s_awaddr, .s_awvalid,
      .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
      .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
      .s_rready, .stop_mode, .loop_filter_in, .generator_output_clock, .bus_clk,
      .osc_enable, .osc_low_power, .osc_range_high, .ref_prescale_one,
      .loop_engaged_external, .loss_detect_on, .active_scheme, .port_g_claim);
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   task automatic conclude;
      if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_b(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask : chk_b
   task automatic chk_rng(input int v, input int lo, input int hi);
      cmp_count++;
      if (v < lo || v > hi) begin
         fails++;
         $display("unexpected at %0t: got %h exp %h..%h", $time, v, lo, hi);
      end
   endtask : chk_rng
   task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
      logic ta, tw, tb;
      int n;
      @(posedge core_clk);
      s_awaddr <= {24'h0, a};
      s_wdata <= {24'h0, d};
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      for (n = 0; n < 64; n++) begin
         @(negedge core_clk);
         ta = s_awready;
         tw = s_wready;
         tb = s_bvalid;
         r = s_bresp;
         @(posedge core_clk);
         if (ta) s_awvalid <= 1'b0;
         if (tw) s_wvalid <= 1'b0;
         if (tb) break;
      end
      s_bready <= 1'b0;
      if (n == 64) begin
         fails++;
         conclude();
      end
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ta, tr;
      int n;
      @(posedge core_clk);
      s_araddr <= {24'h0, a};
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      for (n = 0; n < 64; n++) begin
         @(negedge core_clk);
         ta = s_arready;
         tr = s_rvalid;
         d = s_rdata;
         r = s_rresp;
         @(posedge core_clk);
         if (ta) s_arvalid <= 1'b0;
         if (tr) break;
      end
      s_rready <= 1'b0;
      if (n == 64) begin
         fails++;
         conclude();
      end
   endtask : axi_rd
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [1:0] r;
      axi_wr(a, d, r);
      chk({30'h0, r}, {30'h0, ckg_pkg::RESP_OKAY});
   endtask : wr
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(a, d, r);
      chk(d, e);
      chk({30'h0, r}, {30'h0, ckg_pkg::RESP_OKAY});
   endtask : rd_chk
   task automatic settle;
      repeat (3) @(negedge core_clk);
   endtask : settle
   task automatic count_gen(input int cyc, output int g, output int b);
      logic pg, pb;
      g = 0;
      b = 0;
      pg = generator_output_clock;
      pb = bus_clk;
      repeat (cyc) begin
         @(negedge core_clk);
         if (generator_output_clock && !pg) g++;
         if (bus_clk && !pb) b++;
         pg = generator_output_clock;
         pb = bus_clk;
      end
   endtask : count_gen
   task automatic t_reset;
      chk({30'h0, active_scheme}, 32'h0);
      chk_b(osc_low_power, 1'b1);
      chk_b(osc_range_high, 1'b1);
      chk_b(loss_detect_on, 1'b1);
      rd_chk(A_CTL, {24'h0, ckg_pkg::CTRL_ONE_RST});
      rd_chk(A_TRM, {24'h0, ckg_pkg::TRIM_RST});
      rd_chk(A_UP, {28'h0, ckg_pkg::FILT_RST[11:8]});
      rd_chk(A_LO, {24'h0, ckg_pkg::FILT_RST[7:0]});
   endtask : t_reset
   task automatic t_freq;
      logic [7:0] trims [3] = '{8'h80, 8'h00, 8'hFF};
      int g, b, e;
      foreach (trims[i]) begin
         wr(A_TRM, trims[i]);
         count_gen(1000, g, b);
         // larger trim gives a smaller step, so a longer period
         e = 1000 * ((819 * (640 - int'(trims[i]))) / 512) / 4096;
         chk_rng(g, e - 3, e + 3);
         chk_rng(b, e / 2 - 3, e / 2 + 2);
      end
   endtask : t_freq
   task automatic t_filter;
      wr(A_LO, 8'h55);
      rd_chk(A_LO, {24'h0, ckg_pkg::FILT_RST[7:0]});
      wr(A_UP, 8'h01);
      rd_chk(ckg_pkg::OFS_STATUS, 32'h4);
      wr(A_UP, 8'h09);
      repeat (30) @(negedge core_clk);
      rd_chk(A_UP, 32'h1);
      rd_chk(A_LO, 32'h55);
   endtask : t_filter
   task automatic t_modes;
      wr(A_CTL, 8'h48);
      settle();
      chk({30'h0, active_scheme}, 32'h1);
      chk_b(loop_engaged_external, 1'b0);
      rd_chk(ckg_pkg::OFS_STATUS, 32'h1);
      wr(A_CTL, 8'h50);
      settle();
      chk({30'h0, active_scheme}, 32'h2);
      chk_b(loop_engaged_external, 1'b0);
      wr(A_CTL, 8'h78);
      settle();
      chk({30'h0, active_scheme}, 32'h3);
      chk_b(loop_engaged_external, 1'b1);
      chk_b(osc_low_power, 1'b1);
      chk_b(ref_prescale_one, 1'b1);
      chk({24'h0, port_g_claim}, 32'h6);
      chk_b(osc_enable, 1'b1);
      @(posedge core_clk);
      stop_mode <= 1'b1;
      settle();
      chk_b(osc_enable, 1'b0);
      wr(A_CTL, 8'h7C);
      settle();
      chk_b(osc_enable, 1'b1);
      @(posedge core_clk);
      stop_mode <= 1'b0;
      wr(A_UP, 8'h05);
      rd_chk(A_UP, 32'hA);
      rd_chk(A_LO, 32'hBC);
      wr(A_CTL, 8'h83);
      rd_chk(A_CTL, 32'h82);
      settle();
      chk_b(osc_low_power, 1'b0);
      chk_b(osc_range_high, 1'b0);
      chk_b(loss_detect_on, 1'b0);
      chk({24'h0, port_g_claim}, 32'h0);
   endtask : t_modes
   task automatic t_bad_addr;
      logic [31:0] d;
      logic [1:0] r;
      axi_wr(8'h20, 8'hFF, r);
      chk({30'h0, r}, {30'h0, ckg_pkg::RESP_SLVERR});
      axi_rd(8'h20, d, r);
      chk({30'h0, r}, {30'h0, ckg_pkg::RESP_SLVERR});
      chk(d, 32'h0);
      // without byte lane 0 the write answers but leaves trim alone
      @(posedge core_clk);
      s_wstrb <= 4'h0;
      wr(A_TRM, 8'h11);
      s_wstrb <= 4'hF;
      rd_chk(A_TRM, 32'hFF);
   endtask : t_bad_addr
   initial begin
      fails = 0;
      cmp_count = 0;
      arst_n = 1'b0;
      {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, stop_mode} = 6'h00;
      s_awaddr = 32'h0;
      s_wdata = 32'h0;
      s_araddr = 32'h0;
      s_wstrb = 4'hF;
      loop_filter_in = 12'hABC;
      repeat (10) @(posedge core_clk);
      arst_n <= 1'b1;
      repeat (5) @(negedge core_clk);
      t_reset();
      t_freq();
      t_filter();
      t_modes();
      t_bad_addr();
      conclude();
   end
endmodule : tb_top
